/* verilog/acc_defines.svh */
// Offsets, field positions, reset values and timing counts of the converter control
// Function
// R1: The clock-select field divides the system clock by 2, 8 or 32 for codes 00, 01, 10.
// R2: Clock setting bits 2 to 6 read as zero and ignore writes.
// R3: Clock setting bit 7 is for factory test; software leaves it alone.
// R4: After changing the port configuration, software gives a start pulse within 10 cycles.
// R5: The conversion-pending flag can be read at any time for polling.
// R6: The 8-bit result sits in a read-only register after completion.
// R7: Completion sets the request flag; the interrupt fires only with both enables set.
// R8: The request flag stays set until software writes zero to it.
// R9: A new start pulse right after a read begins the next conversion with no reconfiguration.
// R10: The pending flag reads one while pending or running and clears on completion.
// R11: A rising start bit resets the converter and sets pending; the falling edge starts it.
// R12: Channel codes 000 to 011 select inputs 0 to 3; codes 1xx are unusable.
// R13: Port configuration codes turn 0 to 4 lines analog; code 000 powers the converter off.
// R14: Each conversion samples for 32 converter clocks and finishes in 64.
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_IDX_RESULT     8'h21
`define ACC_IDX_CONTROL    8'h22
`define ACC_IDX_CLKSET     8'h23
`define ACC_IDX_IRQ        8'h24
`define ACC_CH_LSB         0
`define ACC_CFG_LSB        3
`define ACC_PEND_BIT       6
`define ACC_START_BIT      7
`define ACC_CLKSEL_LSB     0
`define ACC_TEST_BIT       7
`define ACC_IRQ_FLAG_BIT   0
`define ACC_IRQ_EN_BIT     1
`define ACC_GIE_BIT        2
`define ACC_RST_CH         3'h0
`define ACC_RST_CFG        3'h0
`define ACC_RST_CLKSEL     2'h0
`define ACC_RST_RESULT     8'h00
`define ACC_DIV_SEL2       6'h01
`define ACC_DIV_SEL8       6'h07
`define ACC_DIV_SEL32      6'h1f
`define ACC_SAMPLE_PERIODS 32
`define ACC_CONV_PERIODS   64
`define ACC_PERIODS_PER_BIT 4
`endif

/* verilog/acc_pkg.sv */
// Types shared by the converter control files
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_IDLE    = 2'b00,
      ACC_ARMED   = 2'b01,
      ACC_SAMPLE  = 2'b10,
      ACC_CONVERT = 2'b11
   } acc_state_t;

   typedef struct packed {
      logic       vld;
      logic       wr;
      logic [7:0] idx;
   } acc_dph_t;

   typedef struct packed {
      logic       pwr;
      logic [3:0] line_mask;
      logic [1:0] ch;
      logic       sample;
      logic [7:0] trial;
   } acc_ana_t;
endpackage : acc_pkg

/* verilog/acc_clkdiv.sv */
// Converter clock tick generator
`include "acc_defines.svh"
module acc_clkdiv (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [1:0] div_sel,
   output logic            tick
);
   import acc_pkg::*;
   logic [5:0] cnt_q;
   logic [5:0] limit;

   // Undefined code 11 falls back to the slowest rate
   always_comb begin
      case (div_sel)
         2'b00:   limit = `ACC_DIV_SEL2;   // [R1]
         2'b01:   limit = `ACC_DIV_SEL8;   // [R1]
         default: limit = `ACC_DIV_SEL32;  // [R1]
      endcase
   end

   assign tick = (cnt_q >= limit);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 6'h00;
      end else if (tick) begin
         cnt_q <= 6'h00;
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   a_div_by_two: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
      (tick && div_sel == 2'b00) ##1 (div_sel == 2'b00)[*2] |-> tick && !$past(tick))
      else $error("divide by two tick spacing wrong");

   a_div_by_eight: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
      (tick && div_sel == 2'b01) ##1 (div_sel == 2'b01)[*8] |-> tick && !$past(tick))
      else $error("divide by eight tick spacing wrong");
endmodule : acc_clkdiv

/* verilog/acc_ctrl.sv */
// Converter control block with AHB-Lite register slave
`include "acc_defines.svh"
module acc_ctrl #(
   parameter int SAMPLE_PERIODS = `ACC_SAMPLE_PERIODS,
   parameter int CONV_PERIODS   = `ACC_CONV_PERIODS
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic [31:0]        hrdata,
   output logic               hreadyout,
   output logic               hresp,
   input  wire logic          sar_cmp,
   output acc_pkg::acc_ana_t  analog,
   output logic               converter_irq
);
   import acc_pkg::*;

   localparam int PERIOD_W = $clog2(CONV_PERIODS);

   generate
      if (SAMPLE_PERIODS < 1 || CONV_PERIODS - SAMPLE_PERIODS != 8 * `ACC_PERIODS_PER_BIT
          || CONV_PERIODS != (1 << PERIOD_W)) begin : g_bad_params
         $error("conversion period counts not supported");
      end
   endgenerate

   acc_dph_t   dph_q;
   logic [31:0] hrdata_q;
   logic [2:0] channel_sel_q;
   logic [2:0] port_analog_cfg_q;
   logic       start_q;
   logic       conversion_pending_flag_q;
   logic [1:0] clk_div_sel_q;
   logic       test_bit_q;
   logic       converter_irq_request_q;
   logic       converter_irq_enable_q;
   logic       global_irq_enable_q;
   logic [7:0] result_q;
   logic [7:0] trial_q;
   logic [7:0] bit_q;
   logic [PERIOD_W-1:0] period_q;
   acc_state_t state_q;
   logic       tick;
   logic       wr_ctrl;
   logic       wr_clk;
   logic       wr_irq;
   logic       start_rise;
   logic       start_fall;
   logic       done;
   logic       decide;
   logic [7:0] kept;

   acc_clkdiv u_clkdiv (
      .hclk    (hclk),
      .hresetn (hresetn),
      .div_sel (clk_div_sel_q),
      .tick    (tick)
   );

   // Zero wait states; every transfer answers OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_q <= '0;
      end else if (hready) begin
         dph_q.vld <= hsel && htrans[1];
         dph_q.wr  <= hwrite;
         dph_q.idx <= (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'hff;
      end
   end

   assign wr_ctrl = dph_q.vld && dph_q.wr && dph_q.idx == `ACC_IDX_CONTROL;
   assign wr_clk  = dph_q.vld && dph_q.wr && dph_q.idx == `ACC_IDX_CLKSET;
   assign wr_irq  = dph_q.vld && dph_q.wr && dph_q.idx == `ACC_IDX_IRQ;

   // Read data captured in the address phase; unmapped reads return zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata_q <= 32'h00000000;
         if (haddr[31:10] == 22'h000000) begin
            case (haddr[9:2])
               `ACC_IDX_RESULT:  hrdata_q[7:0] <= result_q;                      // [R6]
               `ACC_IDX_CONTROL: hrdata_q[7:0] <= {start_q, conversion_pending_flag_q,
                                                   port_analog_cfg_q, channel_sel_q}; // [R5]
               `ACC_IDX_CLKSET:  hrdata_q[7:0] <= {test_bit_q, 5'h00, clk_div_sel_q}; // [R2]
               `ACC_IDX_IRQ:     hrdata_q[7:0] <= {5'h00, global_irq_enable_q,
                                                   converter_irq_enable_q,
                                                   converter_irq_request_q};
               default:          hrdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_sel_q     <= `ACC_RST_CH;
         port_analog_cfg_q <= `ACC_RST_CFG;
         start_q           <= 1'b0;
      end else if (wr_ctrl) begin
         channel_sel_q     <= hwdata[`ACC_CH_LSB +: 3];
         port_analog_cfg_q <= hwdata[`ACC_CFG_LSB +: 3];
         start_q           <= hwdata[`ACC_START_BIT];
      end
   end

   // Test bit is only stored; upper unused bits are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_div_sel_q <= `ACC_RST_CLKSEL;
         test_bit_q    <= 1'b0;
      end else if (wr_clk) begin
         clk_div_sel_q <= hwdata[`ACC_CLKSEL_LSB +: 2];  // [R1] [R2]
         test_bit_q    <= hwdata[`ACC_TEST_BIT];         // [R3]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         converter_irq_enable_q <= 1'b0;
         global_irq_enable_q    <= 1'b0;
      end else if (wr_irq) begin
         converter_irq_enable_q <= hwdata[`ACC_IRQ_EN_BIT];
         global_irq_enable_q    <= hwdata[`ACC_GIE_BIT];
      end
   end

   assign start_rise = wr_ctrl && hwdata[`ACC_START_BIT] && !start_q;
   assign start_fall = wr_ctrl && !hwdata[`ACC_START_BIT] && start_q;
   assign decide     = tick && state_q == ACC_CONVERT && period_q[1:0] == 2'b11;
   assign done       = decide && period_q == PERIOD_W'(CONV_PERIODS - 1);
   assign kept       = sar_cmp ? trial_q : (trial_q & ~bit_q);

   // Restart on any rising start edge, even mid-conversion
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q  <= ACC_IDLE;
         period_q <= '0;
      end else if (start_rise) begin
         state_q  <= ACC_ARMED;                             // [R11]
         period_q <= '0;
      end else if (start_fall && state_q == ACC_ARMED) begin
         state_q  <= ACC_SAMPLE;                            // [R11] [R9]
         period_q <= '0;
      end else if (tick && (state_q == ACC_SAMPLE || state_q == ACC_CONVERT)) begin
         period_q <= period_q + PERIOD_W'(1);               // [R14]
         case (state_q)
            ACC_SAMPLE:  if (period_q == PERIOD_W'(SAMPLE_PERIODS - 1)) state_q <= ACC_CONVERT;
            ACC_CONVERT: if (done) state_q <= ACC_IDLE;     // [R14]
            default:     state_q <= state_q;
         endcase
      end
   end

   // Successive approximation, four converter clocks per bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trial_q <= 8'h80;
         bit_q   <= 8'h80;
      end else if (state_q != ACC_CONVERT) begin
         trial_q <= 8'h80;
         bit_q   <= 8'h80;
      end else if (decide) begin
         trial_q <= kept | (bit_q >> 1);
         bit_q   <= bit_q >> 1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_q <= `ACC_RST_RESULT;
      end else if (done) begin
         result_q <= kept;                                  // [R6]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conversion_pending_flag_q <= 1'b0;
      end else if (start_rise) begin
         conversion_pending_flag_q <= 1'b1;                 // [R11] [R10]
      end else if (done) begin
         conversion_pending_flag_q <= 1'b0;                 // [R10]
      end
   end

   // Completion beats a same-cycle software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         converter_irq_request_q <= 1'b0;
      end else if (done) begin
         converter_irq_request_q <= 1'b1;                   // [R7]
      end else if (wr_irq && !hwdata[`ACC_IRQ_FLAG_BIT]) begin
         converter_irq_request_q <= 1'b0;                   // [R8]
      end
   end

   assign converter_irq = converter_irq_request_q && converter_irq_enable_q
                          && global_irq_enable_q;            // [R7]

   always_comb begin
      analog.ch     = channel_sel_q[1:0];                   // [R12]
      analog.pwr    = port_analog_cfg_q != 3'b000;          // [R13]
      analog.sample = state_q == ACC_SAMPLE;
      analog.trial  = trial_q;
      case (port_analog_cfg_q)
         3'b000:  analog.line_mask = 4'h0;                  // [R13]
         3'b001:  analog.line_mask = 4'h1;
         3'b010:  analog.line_mask = 4'h3;
         3'b011:  analog.line_mask = 4'h7;
         default: analog.line_mask = 4'hf;
      endcase
   end

   sequence s_start_pulse;
      $rose(start_q) ##[1:300] $fell(start_q);
   endsequence

   a_clk_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
      dph_q.vld && !dph_q.wr && dph_q.idx == `ACC_IDX_CLKSET |-> hrdata[6:2] == 5'h00)
      else $error("unused clock setting bits read nonzero");
   a_pend_polled: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
      dph_q.vld && !dph_q.wr && dph_q.idx == `ACC_IDX_CONTROL
      |-> hrdata[`ACC_PEND_BIT] == $past(conversion_pending_flag_q))
      else $error("pending flag read disagrees");
   a_rise_sets_pend: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
      $rose(start_q) |-> conversion_pending_flag_q && state_q == ACC_ARMED)
      else $error("start rise did not reset and set pending");
   a_fall_begins_conv: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
      s_start_pulse |-> state_q == ACC_SAMPLE)
      else $error("start fall did not begin conversion");
   a_sample_length: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
      state_q == ACC_SAMPLE && tick && period_q == PERIOD_W'(SAMPLE_PERIODS - 1)
      && !start_rise |=> state_q == ACC_CONVERT)
      else $error("sample phase length wrong");
   a_done_effects: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
      done && !start_rise |=> !conversion_pending_flag_q && converter_irq_request_q
      && result_q == $past(kept))
      else $error("completion effects missing");
   a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
      converter_irq_request_q && !(wr_irq && !hwdata[`ACC_IRQ_FLAG_BIT]) |=> converter_irq_request_q)
      else $error("request flag cleared without software");
   a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
      converter_irq |-> converter_irq_request_q && converter_irq_enable_q && global_irq_enable_q)
      else $error("interrupt raised without both enables");
   a_req_on_done: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
      $rose(converter_irq_request_q) |-> $past(done))
      else $error("request flag set without completion");
   a_cfg_power: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
      analog.pwr == (analog.line_mask != 4'h0))
      else $error("power and analog lines disagree");
endmodule : acc_ctrl

/* tb/acc_analog_model.sv */
// Behavioural analog core: comparator against a fixed level per channel
module acc_analog_model (
   input  wire logic              hclk,
   input  wire acc_pkg::acc_ana_t analog,
   output logic                   sar_cmp
);
   timeunit 1ns;
   timeprecision 1ns;
   import acc_pkg::*;
   logic [7:0] level;
   logic       flip_q = 1'b0;

   // Powered-off comparator output is meaningless, so it toggles every cycle
   always @(posedge hclk) begin
      flip_q <= ~flip_q;
   end

   always_comb begin
      case (analog.ch)
         2'h0:    level = 8'h5a;
         2'h1:    level = 8'ha5;
         2'h2:    level = 8'h00;
         default: level = 8'hff;
      endcase
      sar_cmp = analog.pwr ? (level >= analog.trial) : flip_q;
   end
endmodule : acc_analog_model

/* tb/adc_conversion_control_tb_top.sv */
// Self-checking bench for the converter control block
`include "acc_defines.svh"
module adc_conversion_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import acc_pkg::*;
   localparam int LIMIT = 40000;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        sar_cmp;
   acc_ana_t    analog;
   logic        converter_irq;
   int          fails = 0;
   int          total_checks = 0;
   int          cyc = 0;
   logic [31:0] rd;

   assign hready = hreadyout;
   always #50 hclk = ~hclk;

   acc_ctrl uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sar_cmp(sar_cmp), .analog(analog),
      .converter_irq(converter_irq)
   );
   acc_analog_model far_side (.hclk(hclk), .analog(analog), .sar_cmp(sar_cmp));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   always @(posedge hclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         fails++;
         $display("Error at %0t: run did not finish in time", $time);
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Both tasks start just after a rising edge and end on one
   task automatic bus_wr(input logic [7:0] idx, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= 1'b1;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwrite <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      // Idle gap so checks made right after the task see the new value
      @(posedge hclk);
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] idx, output logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= 1'b0;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask : bus_rd

   task automatic reset_values;
      bus_rd(`ACC_IDX_CONTROL, rd);
      chk(rd, 32'h0, "control reset");
      bus_rd(`ACC_IDX_CLKSET, rd);
      chk(rd, 32'h0, "clock setting reset");
      bus_rd(`ACC_IDX_RESULT, rd);
      chk(rd, 32'h0, "result reset");
      bus_rd(8'h30, rd);
      chk(rd, 32'h0, "unmapped read");
      chk({31'h0, analog.pwr}, 32'h0, "power off at reset");
      chk({31'h0, hresp}, 32'h0, "okay response");
      chk({31'h0, hreadyout}, 32'h1, "zero wait states");
      chk({24'h0, analog.trial}, 32'h80, "trial value at reset");
   endtask : reset_values

   task automatic clock_setting_bits;
      // Test bit left at zero; bits 6 to 2 written as ones
      bus_wr(`ACC_IDX_CLKSET, 32'h7e);
      bus_rd(`ACC_IDX_CLKSET, rd);
      chk(rd, 32'h02, "unused clock setting bits read zero");
      bus_wr(`ACC_IDX_CLKSET, 32'h00);
   endtask : clock_setting_bits

   task automatic conversion(input logic [1:0] sel, input logic [1:0] ch,
                             input logic [7:0] exp);
      int div;
      int t0;
      int n;
      div = (sel == 2'h0) ? 2 : (sel == 2'h1) ? 8 : 32;
      bus_wr(`ACC_IDX_CLKSET, {30'h0, sel});
      bus_wr(`ACC_IDX_IRQ, 32'h0);
      bus_wr(`ACC_IDX_CONTROL, {24'h0, 2'b10, 3'b100, 1'b0, ch});
      bus_rd(`ACC_IDX_CONTROL, rd);
      chk({24'h0, rd[7:0]}, {24'h0, 2'b11, 3'b100, 1'b0, ch}, "pending set by start rise");
      chk({30'h0, analog.ch}, {30'h0, ch}, "channel routed");
      bus_rd(`ACC_IDX_IRQ, rd);
      chk({31'h0, rd[0]}, 32'h0, "request flag clear before completion");
      t0 = cyc;
      bus_wr(`ACC_IDX_CONTROL, {24'h0, 2'b00, 3'b100, 1'b0, ch});
      chk({31'h0, analog.sample}, 32'h1, "sampling after start fall");
      n = 0;
      bus_rd(`ACC_IDX_CONTROL, rd);
      chk({31'h0, rd[6]}, 32'h1, "pending while running");
      while (rd[6] !== 1'b0 && n < 3000) begin
         bus_rd(`ACC_IDX_CONTROL, rd);
         n++;
      end
      chk({31'h0, (cyc - t0 >= 63 * div) && (cyc - t0 <= 64 * div + 12)}, 32'h1,
          "conversion length");
      chk({31'h0, analog.sample}, 32'h0, "sampling over at completion");
      bus_rd(`ACC_IDX_RESULT, rd);
      chk(rd, {24'h0, exp}, "conversion result");
      bus_rd(`ACC_IDX_IRQ, rd);
      chk({31'h0, rd[0]}, 32'h1, "request flag set on completion");
   endtask : conversion

   task automatic irq_gating;
      bus_wr(`ACC_IDX_IRQ, 32'h3);
      chk({31'h0, converter_irq}, 32'h0, "no irq without global enable");
      bus_wr(`ACC_IDX_IRQ, 32'h5);
      chk({31'h0, converter_irq}, 32'h0, "no irq without converter enable");
      bus_wr(`ACC_IDX_IRQ, 32'h7);
      chk({31'h0, converter_irq}, 32'h1, "irq with both enables");
      bus_wr(`ACC_IDX_CONTROL, 32'h80);
      chk({31'h0, converter_irq}, 32'h1, "start rise keeps request");
      bus_wr(`ACC_IDX_IRQ, 32'h6);
      chk({31'h0, converter_irq}, 32'h0, "request cleared by zero");
      bus_rd(`ACC_IDX_IRQ, rd);
      chk(rd, 32'h6, "irq register after clear");
   endtask : irq_gating

   task automatic port_config;
      logic [3:0] mask;
      for (int c = 0; c < 8; c++) begin
         mask = (c >= 4) ? 4'hf : 4'((1 << c) - 1);
         bus_wr(`ACC_IDX_CONTROL, {26'h0, 3'(c), 3'h1});
         chk({27'h0, analog.pwr, analog.line_mask}, {27'h0, c != 0, mask},
             "port lines made analog");
         // Each change is followed by a start pulse
         bus_wr(`ACC_IDX_CONTROL, {24'h0, 2'b10, 3'(c), 3'h1});
         bus_wr(`ACC_IDX_CONTROL, {26'h0, 3'(c), 3'h1});
      end
      // Start pulse after the last change re-arms the converter
      bus_wr(`ACC_IDX_CONTROL, 32'ha1);
      bus_wr(`ACC_IDX_CONTROL, 32'h21);
   endtask : port_config

   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      reset_values();
      clock_setting_bits();
      conversion(2'h0, 2'h0, 8'h5a);
      conversion(2'h1, 2'h1, 8'ha5);
      conversion(2'h2, 2'h2, 8'h00);
      conversion(2'h2, 2'h2, 8'h00);
      conversion(2'h0, 2'h3, 8'hff);
      irq_gating();
      port_config();
      complete_run();
   end
endmodule : adc_conversion_control_tb_top
